// file: rtl/wdlp_top.sv
// Purpose: watchdog behaviour across slow, wait, halt and active halt modes
// Assumes: halt, wake and refresh requests are one-cycle pulses synchronous to CLK
// Notes: the halt-reset and hardware-forced options are static straps
// Overview of operation
// - In slow and wait mode the watchdog counts and resets exactly as in run mode.
// - A halt with oscillator interrupt off and halt-reset option clear gives no reset and halts.
// - On entering halt the counter decrements once, then freezes until external interrupt or reset.
// - An external interrupt out of halt restarts counting after 256 or 4096 cycles.
// - A reset out of halt returns the watchdog to its disabled state unless forced on.
// - A halt with oscillator interrupt off and halt-reset option set gives a reset instead.
// - A halt with oscillator interrupt on enters active halt with no reset.
// - In active halt the counter holds its value with no decrement.
// - An oscillator or external interrupt out of active halt restarts counting at once.
// - A reset out of active halt restarts counting after 256 or 4096 cycles.
// - With the hardware-forced option the watchdog is always active, the activate bit unused.
`timescale 1ns/100ps
`include "wdlp_cfg.svh"
module wdlp_top import wdlp_pkg::*; #(
   parameter logic [12:0] SHORT_CYC = `WDLP_DELAY_SHORT,
   parameter logic [12:0] LONG_CYC = `WDLP_DELAY_LONG
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // register port
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // power mode and wake events
   input wire logic HALT_REQ,
   input wire logic EXT_IRQ,
   input wire logic OSC_IRQ,
   input wire logic OSC_IRQ_ENABLE,
   input wire logic SLOW_MODE,
   input wire logic WAIT_MODE,
   // straps
   input wire logic HALT_RESET_OPTION,
   input wire logic HW_WATCHDOG,
   input wire logic LONG_DELAY_SEL,
   // outputs
   output logic RESET_REQ,
   output logic HALTED,
   output logic ACTIVE_HALTED,
   output logic IRQ
);
   wdlp_bus_t bus;
   wdlp_state_t state;
   logic wdg_active;
   logic [6:0] counter;
   logic [2:0] status;
   logic [2:0] mask;
   logic resumed_by_reset;
   logic delay_start;
   logic delay_busy;
   logic delay_done;
   logic running;
   logic wdg_fire;
   logic halt_rst_fire;
   logic wake_ev;
   logic ctrl_write;
   logic timed_out;
   logic [7:0] next_rdata;

   assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
   assign ctrl_write = bus.wr && bus.addr == `WDLP_REG_CTRL;
   // slow and wait inputs are deliberately unused: counting ignores them
   assign running = (state == WDLP_RUN) && (wdg_active || HW_WATCHDOG);
   // counter holds at the timeout value, so fire only once per timeout
   assign wdg_fire = running && !ctrl_write && counter[6] == 1'b0 && !timed_out;
   assign halt_rst_fire = HALT_REQ && state == WDLP_RUN && !OSC_IRQ_ENABLE
      && HALT_RESET_OPTION;
   assign wake_ev = EXT_IRQ || OSC_IRQ;

   wdlp_delay #(
      .SHORT_CYC(SHORT_CYC),
      .LONG_CYC(LONG_CYC)
   ) u_delay (
      .clk(CLK),
      .reset(RESET),
      .start(delay_start),
      .use_long(LONG_DELAY_SEL),
      .busy(delay_busy),
      .done(delay_done)
   );

   // power state; a reset from active halt is modelled as a pulse on RESET,
   // so the delayed restart after it starts from the post-reset state
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         state <= WDLP_WAKE_WAIT;
         delay_start <= 1'b1;
      end else begin
         delay_start <= 1'b0;
         case (state)
            WDLP_RUN: begin
               if (HALT_REQ && !halt_rst_fire) begin
                  if (OSC_IRQ_ENABLE) begin
                     state <= WDLP_AHALT;
                  end else begin
                     state <= WDLP_HALT_ENTRY;
                  end
               end
            end
            WDLP_HALT_ENTRY: begin
               state <= WDLP_HALT;
            end
            WDLP_HALT: begin
               if (EXT_IRQ) begin
                  state <= WDLP_WAKE_WAIT;
                  delay_start <= 1'b1;
               end
            end
            WDLP_AHALT: begin
               if (wake_ev) begin
                  state <= WDLP_RUN;
               end
            end
            WDLP_WAKE_WAIT: begin
               if (delay_done) begin
                  state <= WDLP_RUN;
               end
            end
            default: begin
               state <= WDLP_RUN;
            end
         endcase
      end
   end

   // set on entry to active halt; cleared by reset or by the next cycle back in run
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         resumed_by_reset <= 1'b0;
      end else if (HALT_REQ && state == WDLP_RUN && OSC_IRQ_ENABLE) begin
         resumed_by_reset <= 1'b1;
      end else if (state == WDLP_RUN) begin
         resumed_by_reset <= 1'b0;
      end
   end

   // activate bit: cleared by reset, so a reset out of halt disables the
   // watchdog unless the strap forces it
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         wdg_active <= 1'b0;
      end else if (ctrl_write && bus.wdata[`WDLP_CTRL_ACT]) begin
         wdg_active <= 1'b1;
      end
   end

   // one reset request per timeout; a refresh re-arms it
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         timed_out <= 1'b0;
      end else if (ctrl_write) begin
         timed_out <= 1'b0;
      end else if (wdg_fire) begin
         timed_out <= 1'b1;
      end
   end

   // counter: bit 6 low means timeout, refresh is a write to the control word
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         counter <= 7'(`WDLP_CTRL_RESET);
      end else if (ctrl_write) begin
         counter <= bus.wdata[6:0];
      end else if (state == WDLP_HALT_ENTRY && (wdg_active || HW_WATCHDOG)) begin
         counter <= counter - 7'h01;
      end else if (running && counter[6]) begin
         counter <= counter - 7'h01;
      end
      // halt, active halt and wake wait hold the value
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         RESET_REQ <= 1'b0;
      end else begin
         RESET_REQ <= wdg_fire || halt_rst_fire;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         HALTED <= 1'b0;
         ACTIVE_HALTED <= 1'b0;
      end else begin
         // an interrupt during halt entry does not wake, so only halt drops it
         HALTED <= state == WDLP_HALT_ENTRY || (state == WDLP_HALT && !EXT_IRQ);
         ACTIVE_HALTED <= state == WDLP_AHALT && !wake_ev;
      end
   end

   // sticky events: set wins over the read that clears
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         status <= 3'h0;
      end else begin
         status <= ((bus.rd && bus.addr == `WDLP_REG_STATUS) ? 3'h0 : status)
            | {delay_done, halt_rst_fire, wdg_fire};
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         mask <= 3'h0;
      end else if (bus.wr && bus.addr == `WDLP_REG_MASK) begin
         mask <= bus.wdata[2:0];
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(status & mask);
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      if (bus.addr == `WDLP_REG_CTRL) begin
         next_rdata = {wdg_active || HW_WATCHDOG, counter};
      end else if (bus.addr == `WDLP_REG_COUNT) begin
         next_rdata = {1'b0, counter};
      end else if (bus.addr == `WDLP_REG_STATUS) begin
         next_rdata = {5'h00, status};
      end else if (bus.addr == `WDLP_REG_MASK) begin
         next_rdata = {5'h00, mask};
      end else if (bus.addr == `WDLP_REG_STATE) begin
         next_rdata = {3'h0, resumed_by_reset, delay_busy, state};
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         RDATA <= 8'h00;
      end else if (bus.rd) begin
         RDATA <= next_rdata;
      end else begin
         RDATA <= 8'h00;
      end
   end
endmodule // wdlp_top

// file: shared/wdlp_cfg.svh
// Purpose: constants for the watchdog low-power handling block
// Assumes: 100 MHz CPU clock
// Notes: register offsets are word indices on the plain register port
`ifndef WDLP_CFG_SVH
`define WDLP_CFG_SVH
`define WDLP_REG_CTRL 4'h0
`define WDLP_REG_COUNT 4'h1
`define WDLP_REG_STATUS 4'h2
`define WDLP_REG_MASK 4'h3
`define WDLP_REG_STATE 4'h4
`define WDLP_CTRL_ACT 7
`define WDLP_CTRL_RESET 8'h7F
`define WDLP_DELAY_SHORT 13'h0100
`define WDLP_DELAY_LONG 13'h1000
`define WDLP_ST_WDRST 0
`define WDLP_ST_HALTRST 1
`define WDLP_ST_WAKE 2
`endif

// file: shared/wdlp_pkg.sv
// Purpose: types for the watchdog low-power handling block
// Assumes: nothing
// Notes: state codes are binary
package wdlp_pkg;
   typedef enum logic [2:0] {
      WDLP_RUN = 3'h0,
      WDLP_HALT_ENTRY = 3'h1,
      WDLP_HALT = 3'h2,
      WDLP_AHALT = 3'h3,
      WDLP_WAKE_WAIT = 3'h4
   } wdlp_state_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } wdlp_bus_t;
endpackage

// file: rtl/wdlp_delay.sv
// Purpose: restart delay counter for the watchdog after wake-up
// Assumes: start is a one-cycle pulse
// Notes: done pulses once when the chosen count has elapsed
`timescale 1ns/100ps
`include "wdlp_cfg.svh"
module wdlp_delay import wdlp_pkg::*; #(
   parameter logic [12:0] SHORT_CYC = `WDLP_DELAY_SHORT,
   parameter logic [12:0] LONG_CYC = `WDLP_DELAY_LONG
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic start,
   input wire logic use_long,
   output logic busy,
   output logic done
);
   logic [12:0] count;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count <= 13'h0000;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            count <= (use_long ? LONG_CYC : SHORT_CYC) - 13'h0001;
            busy <= 1'b1;
         end else if (busy) begin
            if (count == 13'h0001 || count == 13'h0000) begin
               busy <= 1'b0;
               done <= 1'b1;
               count <= 13'h0000;
            end else begin
               count <= count - 13'h0001;
            end
         end
      end
   end
endmodule // wdlp_delay

// file: test/wdlp_chk_sva.sv
// Purpose: port-level checker for wdlp_top
// Assumes: bound to every wdlp_top instance
// Notes: wake bounds allow one cycle of output registering
`timescale 1ns/100ps
module wdlp_chk (
   // clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // watched ports
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic EXT_IRQ,
   input wire logic OSC_IRQ,
   input wire logic OSC_IRQ_ENABLE,
   input wire logic HALT_RESET_OPTION,
   input wire logic RESET_REQ,
   input wire logic HALTED,
   input wire logic ACTIVE_HALTED
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   sequence s_ahalt_wake;
      ACTIVE_HALTED && (EXT_IRQ || OSC_IRQ);
   endsequence
   rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
      else $error("read data outside read slot");
   pulse_once_a: assert property (RESET_REQ |=> !RESET_REQ)
      else $error("reset request longer than one cycle");
   halt_block_a: assert property (HALT_RESET_OPTION && !OSC_IRQ_ENABLE |-> !HALTED)
      else $error("halted although reset option set");
   halt_cause_a: assert property ($rose(HALTED) |-> !OSC_IRQ_ENABLE)
      else $error("halt entered with osc irq enabled");
   ahalt_cause_a: assert property ($rose(ACTIVE_HALTED) |-> OSC_IRQ_ENABLE)
      else $error("active halt without osc irq enable");
   halt_quiet_a: assert property (HALTED && $past(HALTED) |-> !RESET_REQ)
      else $error("reset request while halted");
   ahalt_quiet_a: assert property (ACTIVE_HALTED [*2] |-> !RESET_REQ)
      else $error("reset request in active halt");
   ahalt_wake_a: assert property (s_ahalt_wake |-> ##[1:2] !ACTIVE_HALTED)
      else $error("active halt not left on wake");
   halt_wake_a: assert property (HALTED && EXT_IRQ |-> ##[1:2] !HALTED)
      else $error("halt not left on external irq");
endmodule // wdlp_chk
bind wdlp_top wdlp_chk u_wdlp_chk (.CLK(CLK), .RESET(RESET), .RD(RD), .RDATA(RDATA),
   .EXT_IRQ(EXT_IRQ), .OSC_IRQ(OSC_IRQ), .OSC_IRQ_ENABLE(OSC_IRQ_ENABLE),
   .HALT_RESET_OPTION(HALT_RESET_OPTION), .RESET_REQ(RESET_REQ), .HALTED(HALTED),
   .ACTIVE_HALTED(ACTIVE_HALTED));

// file: test/wdlp_top_tb.sv
// Purpose: directed bench for wdlp_top
// Assumes: restart delays shortened to 4 and 8 cycles
// Notes: straps change only under reset, as on a real part
`timescale 1ns/100ps
module wdlp_top_tb;
   localparam int SHORT = 4;
   localparam int LONG = 8;
   localparam int TMO = 8'h45 - 8'h3F;
   logic CLK = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0, HALT_REQ = 1'b0, EXT_IRQ = 1'b0;
   logic OSC_IRQ = 1'b0, OSC_IRQ_ENABLE = 1'b0, SLOW_MODE = 1'b0, WAIT_MODE = 1'b0;
   logic HALT_RESET_OPTION = 1'b0, HW_WATCHDOG = 1'b0, LONG_DELAY_SEL = 1'b0;
   logic [3:0] ADDR = 4'h0;
   logic [7:0] WDATA = 8'h00, RDATA, d, c0;
   logic RESET_REQ, HALTED, ACTIVE_HALTED, IRQ;
   int n_mismatch = 0, total_checks = 0, n_rreq = 0, k, r0;
   wdlp_top #(.SHORT_CYC(13'(SHORT)), .LONG_CYC(13'(LONG))) u_wdlp_top (.CLK(CLK),
      .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .HALT_REQ(HALT_REQ), .EXT_IRQ(EXT_IRQ), .OSC_IRQ(OSC_IRQ),
      .OSC_IRQ_ENABLE(OSC_IRQ_ENABLE), .SLOW_MODE(SLOW_MODE), .WAIT_MODE(WAIT_MODE),
      .HALT_RESET_OPTION(HALT_RESET_OPTION), .HW_WATCHDOG(HW_WATCHDOG),
      .LONG_DELAY_SEL(LONG_DELAY_SEL), .RESET_REQ(RESET_REQ), .HALTED(HALTED),
      .ACTIVE_HALTED(ACTIVE_HALTED), .IRQ(IRQ));
   always #5 CLK = ~CLK;
   always @(posedge CLK) if (RESET_REQ === 1'b1) n_rreq++;
   task automatic chk(input logic [7:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge CLK) {ADDR, WDATA, WR} <= {a, v, 1'b1};
      @(posedge CLK) WR <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge CLK) {ADDR, RD} <= {a, 1'b1};
      @(posedge CLK) RD <= 1'b0;
      #1 v = RDATA;
   endtask
   // 4 halt, 2 external irq, 1 oscillator irq
   task automatic pulse(input int s);
      @(posedge CLK) {HALT_REQ, EXT_IRQ, OSC_IRQ} <= 3'(s);
      @(posedge CLK) {HALT_REQ, EXT_IRQ, OSC_IRQ} <= 3'h0;
   endtask
   // every reset is followed by the restart delay in wake-wait
   task automatic rst(input logic opt, hw, lng);
      @(posedge CLK) {RESET, HALT_RESET_OPTION, HW_WATCHDOG, LONG_DELAY_SEL} <=
         {1'b1, opt, hw, lng};
      repeat (8) @(posedge CLK);
      RESET <= 1'b0;
      cyc((lng ? LONG : SHORT) - 3);
      rd(4'h4, d);
      chk(d & 8'h07, 8'h04);
      cyc(4);
      rd(4'h4, d);
      chk(d & 8'h07, 8'h00);
   endtask
   task automatic tmo(input logic [7:0] v, input logic fire);
      wr(4'h0, v);
      k = 0;
      #1;
      while (RESET_REQ !== 1'b1 && k < 20) begin
         @(posedge CLK);
         #1 k++;
      end
      chk(8'(fire ? (k >= TMO && k <= TMO + 3) : (k == 20)), 8'h01);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      rst(0, 0, 0);
      rd(4'h0, d);
      chk(d, 8'h7F);
      wr(4'hF, 8'hAA);
      rd(4'hF, d);
      chk(d, 8'h00);
      tmo(8'h45, 1'b0);
      for (int m = 0; m < 4; m++) begin
         @(posedge CLK) {WAIT_MODE, SLOW_MODE} <= 2'(m);
         wr(4'h3, 8'(m != 3));
         tmo(8'hC5, 1'b1);
         cyc(2);
         chk({7'h00, IRQ}, 8'(m != 3));
         rd(4'h2, d);
         chk(d & 8'h01, 8'h01);
         cyc(2);
         chk({7'h00, IRQ}, 8'h00);
      end
      rst(0, 0, 1);
      wr(4'h0, 8'hFF);
      pulse(4);
      cyc(4);
      chk({7'h00, HALTED}, 8'h01);
      rd(4'h1, c0);
      // two run decrements before the halt is taken, then exactly one on entry
      chk(c0, 8'h7C);
      r0 = n_rreq;
      cyc(150);
      rd(4'h1, d);
      chk(d, c0);
      chk(8'(n_rreq - r0), 8'h00);
      pulse(2);
      cyc(1);
      chk({7'h00, HALTED}, 8'h00);
      rd(4'h1, d);
      chk(d, c0);
      cyc(LONG + 3);
      rd(4'h1, d);
      chk(8'(d < c0), 8'h01);
      pulse(4);
      rst(1, 0, 0);
      rd(4'h0, d);
      chk(d, 8'h7F);
      wr(4'h0, 8'hFF);
      r0 = n_rreq;
      pulse(4);
      cyc(3);
      chk(8'(n_rreq - r0), 8'h01);
      chk({7'h00, HALTED}, 8'h00);
      rd(4'h2, d);
      chk(d & 8'h02, 8'h02);
      @(posedge CLK) OSC_IRQ_ENABLE <= 1'b1;
      for (int w = 1; w < 4; w++) begin
         wr(4'h0, 8'hFF);
         pulse(4);
         cyc(3);
         chk({7'h00, ACTIVE_HALTED}, 8'h01);
         rd(4'h1, c0);
         // two run decrements only: active halt takes none on entry
         chk(c0, 8'h7D);
         r0 = n_rreq;
         cyc(100);
         rd(4'h1, d);
         chk(d, c0);
         chk(8'(n_rreq - r0), 8'h00);
         if (w < 3) begin
            pulse(w);
            cyc(2);
            rd(4'h4, d);
            chk(d & 8'h07, 8'h00);
         end
      end
      rst(0, 1, 0);
      rd(4'h0, d);
      chk(d & 8'h80, 8'h80);
      tmo(8'h45, 1'b1);
      end_sim;
   end
   initial begin
      #50000;
      n_mismatch++;
      end_sim;
   end
endmodule // wdlp_top_tb
